// [dv/aic_host_model.sv]
// Behavioural SPI host controller driving the control port
`timescale 1ns/1ps
module aic_host_model (
	input wire logic i_mclk, // Master clock
	input wire logic i_start, // Start one frame
	input wire logic [15:0] i_word, // Command word
	input wire logic i_miso, // Device answer line
	output logic o_sclk, // SPI clock, idle low
	output logic o_cs_n, // Select, active low
	output logic o_mosi, // Command line
	output logic [15:0] o_rdata, // Answer of this frame
	output logic o_done // Pulse after frame end
);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		o_rdata = 16'h0000;
		o_done = 1'b0;
	end
	// One frame per start; half period of 8 mclk keeps sclk slow for the synchronisers
	always @(posedge i_mclk) begin
		o_done <= 1'b0;
		if (i_start) begin
			o_cs_n <= 1'b0;
			repeat (8) @(posedge i_mclk);
			for (int i = 15; i >= 0; i--) begin
				o_mosi <= i_word[i];
				repeat (8) @(posedge i_mclk);
				o_sclk <= 1'b1;
				o_rdata <= {o_rdata[14:0], i_miso};
				repeat (8) @(posedge i_mclk);
				o_sclk <= 1'b0;
			end
			repeat (8) @(posedge i_mclk);
			o_cs_n <= 1'b1;
			// Released line never keeps the last bit
			o_mosi <= ~o_mosi;
			repeat (8) @(posedge i_mclk);
			o_done <= 1'b1;
		end
	end
endmodule : aic_host_model

// [dv/aic_tb_top.sv]
// Self-checking bench for the interface control block
`timescale 1ns/1ps
module aic_tb_top;
	logic clk = 1'b0, rst = 1'b1, sync = 1'b0, settled = 1'b1, sv = 1'b0, start = 1'b0;
	logic [2:0] sch = 3'h0;
	logic [7:0] sst = 8'h00;
	logic [15:0] sdat = 16'h0000, word = 16'h0000, rdata;
	logic sclk, cs_n, mosi, miso, srdy, frst, crst, data_output_clock, lane, frame, done;
	int num_errors = 0, samples_checked = 0, cycles = 0, nrst = 0, nfrst = 0, nstall = 0;
	logic [31:0] lfsr_q = 32'h4b3f;
	logic [7:0] crc_q [8];
	int cnt_q [8];
	logic [23:0] exp_q [$];
	logic [1:0] crc_mode = 2'h0;

	aic_top dut (.i_mclk(clk), .i_sys_rst(rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
		.i_spi_mosi(mosi), .o_spi_miso(miso), .i_sync_in(sync), .i_filter_settled(settled),
		.i_sample_valid(sv), .i_sample_chan(sch), .i_sample_status(sst),
		.i_sample_data(sdat), .o_sample_ready(srdy), .o_filter_reset(frst),
		.o_core_reset(crst), .o_data_output_clock(data_output_clock), .o_data_output_lanes(lane),
		.o_data_frame(frame));
	aic_host_model host (.i_mclk(clk), .i_start(start), .i_word(word), .i_miso(miso),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .o_rdata(rdata), .o_done(done));

	always #5 clk = ~clk;
	// Pulse counters and the cycle ceiling that cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (crst === 1'b1) nrst++;
		if (frst === 1'b1) nfrst++;
		if (sv === 1'b1 && srdy === 1'b0 && !rst) nstall++;
		if (cycles == 60000) begin
			num_errors++;
			test_done();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Bitwise CRC, polynomial x^8 + x^2 + x + 1, data MSB first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [15:0] d);
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// One SPI frame; the answer belongs to the previous frame
	task automatic spi(input logic [15:0] w, output logic [15:0] r);
		@(posedge clk) begin
			start <= 1'b1;
			word <= w;
		end
		@(posedge clk) start <= 1'b0;
		do @(posedge clk); while (done !== 1'b1);
		r = rdata;
	endtask : spi
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [15:0] r;
		spi({1'b0, a, d}, r);
	endtask : wr
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		logic [15:0] r;
		spi({1'b1, a, 8'h00}, r);
		spi(16'h8700, r);
		check({8'h00, r}, {9'h001, a, e});
	endtask : rdchk
	// Offer one sample; keep says whether a word must come out of it
	task automatic push(input logic [2:0] ch, input logic keep);
		logic [15:0] d;
		lfsr_q = lfsr(lfsr_q);
		d = lfsr_q[23:8];
		if (keep) begin
			crc_q[ch] = crc8(crc_q[ch], d);
			cnt_q[ch]++;
			if (crc_mode != 2'h0 && cnt_q[ch] % (crc_mode == 2'h1 ? 4 : 16) == 0) begin
				exp_q.push_back({crc_q[ch], d});
				crc_q[ch] = 8'h00;
			end else
				exp_q.push_back({lfsr_q[7:0], d});
		end
		@(posedge clk) begin
			sv <= 1'b1;
			sch <= ch;
			sst <= lfsr_q[7:0];
			sdat <= d;
		end
		do @(posedge clk); while (srdy !== 1'b1);
		sv <= 1'b0;
	endtask : push
	// Capture one word of n cycles a bit and check the data clock phase
	task automatic pull(input int n);
		logic [23:0] w;
		logic ck;
		int t;
		t = 0;
		ck = 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (frame !== 1'b1 && t < 3000);
		for (int b = 23; b >= 0; b--) begin
			w[b] = lane;
			ck &= (data_output_clock === (n == 1));
			repeat (n - 1) @(posedge clk);
			ck &= (data_output_clock === 1'b1);
			if (b != 0) @(posedge clk);
		end
		check(w, exp_q.pop_front());
		check({23'h0, ck}, 24'h1);
	endtask : pull
	task automatic none();
		int f;
		f = 0;
		repeat (400) @(posedge clk) f += (frame === 1'b1);
		check(f, 0);
	endtask : none
	task automatic run(input logic [1:0] dv, input logic [1:0] cm, input int n);
		wr(7'h06, 8'h03);
		wr(7'h06, 8'h02);
		crc_mode = cm;
		foreach (crc_q[i]) begin
			crc_q[i] = 8'h00;
			cnt_q[i] = 0;
		end
		wr(7'h07, {4'h0, cm, dv});
		fork
			for (int k = 0; k < n; k++) push(lfsr_q[26:24] & (cm[1] ? 3'h1 : 3'h7), 1'b1);
			for (int k = 0; k < n; k++) pull(8 >> dv);
		join
	endtask : run

	initial begin
		logic [15:0] r;
		int base;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rdchk(7'h07, 8'h00);
		rdchk(7'h06, 8'h80);
		lfsr_q = lfsr(lfsr_q);
		wr(7'h07, lfsr_q[7:0]);
		rdchk(7'h07, {4'h0, lfsr_q[3:0]});
		wr(7'h05, 8'hff);
		rdchk(7'h05, 8'h00);
		wr(7'h06, 8'h10);
		rdchk(7'h06, 8'h10);
		// Broken or out-of-order reset sequences must do nothing
		wr(7'h06, 8'h03);
		wr(7'h07, 8'h05);
		wr(7'h06, 8'h02);
		wr(7'h06, 8'h01);
		wr(7'h06, 8'h02);
		wr(7'h06, 8'h00);
		wr(7'h06, 8'h02);
		check(nrst, 0);
		wr(7'h06, 8'h03);
		rdchk(7'h07, 8'h05);
		wr(7'h06, 8'h02);
		check(nrst, 1);
		spi(16'h8700, r);
		spi(16'h8600, r);
		check({8'h00, r}, {8'h00, aic_pkg::POST_RST_WORD});
		rdchk(7'h07, 8'h00);
		rdchk(7'h06, 8'h80);
		// Every divider and CRC setting; the slow one stalls the sender
		run(2'h0, 2'h0, 24);
		check({23'h0, nstall > 0}, 24'h1);
		run(2'h1, 2'h1, 32);
		run(2'h2, 2'h2, 40);
		// the no-division setting the host needs for dense output
		run(2'h3, 2'h3, 40);
		crc_mode = 2'h0;
		// Back to no CRC and divide by 8 for the sync and one-shot cases
		wr(7'h07, 8'h00);
		// Sync resets the filters once; nothing leaves before they settle
		base = nfrst;
		@(posedge clk) begin
			sync <= 1'b1;
			settled <= 1'b0;
		end
		repeat (8) @(posedge clk);
		check(nfrst - base, 1);
		push(3'h0, 1'b0);
		none();
		@(posedge clk) begin
			sync <= 1'b0;
			settled <= 1'b1;
		end
		fork
			push(3'h1, 1'b1);
			pull(8);
		join
		// One-shot: a single result per sync rising edge
		wr(7'h06, 8'h10);
		push(3'h2, 1'b0);
		none();
		@(posedge clk) sync <= 1'b1;
		repeat (8) @(posedge clk);
		sync <= 1'b0;
		fork
			push(3'h2, 1'b1);
			pull(8);
		join
		push(3'h2, 1'b0);
		none();
		test_done();
	end
endmodule : aic_tb_top

// [rtl/aic_buf2.sv]
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module aic_buf2 #(
	parameter int W = 27
) (
	input wire logic i_mclk, // Master clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic i_valid, // Write side valid
	input wire logic [W-1:0] i_data, // Write side data
	output logic o_ready, // Write side ready, registered
	output logic o_valid, // Read side valid
	output logic [W-1:0] o_data, // Read side data
	input wire logic i_ready // Read side ready
);
	logic [W-1:0] mem_q [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;

	// Handshakes; ready is a flop so a stall never ripples combinationally
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_valid = (cnt_q != 2'h0);
	assign o_data = mem_q[rd_ptr_q];
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	// Pointer and count update
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			cnt_q <= 2'h0;
			o_ready <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q ^ push;
			rd_ptr_q <= rd_ptr_q ^ pop;
			cnt_q <= cnt_d;
			o_ready <= (cnt_d != 2'h2);
		end
	end

	// Storage
	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_data;
		end
	end

	property p_full_stalls;
		@(posedge i_mclk) disable iff (i_rst) (cnt_q == 2'h2) |-> !o_ready;
	endproperty
	a_full_stalls: assert property (p_full_stalls) else $error("buffer full but ready");
endmodule : aic_buf2

// [rtl/aic_pkg.sv]
// Constants for the converter interface control block
package aic_pkg;
	// ---------------------------------------------------------------
	// Register map (SPI address space)
	// ---------------------------------------------------------------
	localparam logic [6:0] REG_DATA_CTRL = 7'h06;
	localparam logic [6:0] REG_IFC_CFG = 7'h07;
	localparam logic [7:0] DATA_CTRL_RST = 8'h80;
	localparam logic [3:0] IFC_CFG_RST = 4'h0;
	localparam int DC_SYNC_BIT = 7;
	localparam int DC_ONESHOT_BIT = 4;
	localparam int IFC_CRC_LSB = 2;
	localparam int IFC_DIV_LSB = 0;
	// ---------------------------------------------------------------
	// Soft reset and SPI framing
	// ---------------------------------------------------------------
	localparam logic [1:0] SR_FIRST = 2'h3;
	localparam logic [1:0] SR_SECOND = 2'h2;
	localparam logic [15:0] POST_RST_WORD = 16'h0e00;
	localparam logic [4:0] SPI_LAST_BIT = 5'h0f;
	// ---------------------------------------------------------------
	// CRC and data framing
	// ---------------------------------------------------------------
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [1:0] CRC_OFF = 2'h0;
	localparam logic [1:0] CRC_EVERY4 = 2'h1;
	localparam logic [3:0] CRC_LAST4 = 4'h3;
	localparam logic [3:0] CRC_LAST16 = 4'hf;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [3:0] DIV_MAX = 4'h8;
endpackage : aic_pkg

// [rtl/aic_top.sv]
// Interface control: SPI registers, soft reset, one-shot, CRC framing, data clock
// Summary of operation
// R1: One-shot enabled: one conversion result per sync rising edge; clear disables it.
// R2: Soft reset needs write 3 then write 2 to the reset field; 0 and 1 ignored.
// R3: Completed soft reset sequence resets core and returns registers to defaults.
// R4: First command after soft reset is answered next frame with 0x0E00.
// R5: CRC select 00: no CRC, status header sent with every sample.
// R6: CRC select 01: every fourth sample header replaced by CRC byte.
// R7: CRC select 10 or 11: every sixteenth sample header replaced by CRC.
// R8: CRC uses polynomial x^8 + x^2 + x + 1.
// R9: CRC kept per channel, covering that channel's conversion data only.
// R10: Divider field 00/01/10/11 gives master clock divided by 8/4/2/1.
// R11: Data clock derives from master clock and shifts data out on the lane.
// R12: Host picks no division when decimate-by-32 runs on two lanes.
// R13: Interface configuration at address 0x07, reset 0x0: no CRC, divide by 8.
// R14: Every sync pulse resets filters; no output until filters settle.
// R15: Undefined register bits ignore writes and read as zero.
`timescale 1ns/1ps
module aic_top #(
	parameter int NCH = 8, // Channels
	parameter int CH_W = 3 // Channel index width
) (
	input wire logic i_mclk, // Master clock, 100 MHz
	input wire logic i_sys_rst, // Synchronous reset, active high
	input wire logic i_spi_sclk, // SPI clock pin
	input wire logic i_spi_cs_n, // SPI chip select pin, active low
	input wire logic i_spi_mosi, // SPI data in pin
	output logic o_spi_miso, // SPI data out
	input wire logic i_sync_in, // Sync pin
	input wire logic i_filter_settled, // Filters settled, from core
	input wire logic i_sample_valid, // Conversion sample valid
	input wire logic [CH_W-1:0] i_sample_chan, // Sample channel
	input wire logic [7:0] i_sample_status, // Status header byte
	input wire logic [15:0] i_sample_data, // Conversion data
	output logic o_sample_ready, // Sample taken
	output logic o_filter_reset, // Pulse: reset filters
	output logic o_core_reset, // Pulse: soft reset of core
	output logic o_data_output_clock, // Data output clock
	output logic o_data_output_lanes, // Serial data lane
	output logic o_data_frame // High on first bit of a word
);
	localparam int BW = CH_W + 24;
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] mosi_s;
	logic [2:0] sync_s;

	// Two flops before use; third stage only feeds edge detection
	always_ff @(posedge i_mclk) begin
		sclk_s <= {sclk_s[1:0], i_spi_sclk};
		cs_s <= {cs_s[1:0], i_spi_cs_n};
		mosi_s <= {mosi_s[0], i_spi_mosi};
		sync_s <= {sync_s[1:0], i_sync_in};
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic sel;
	logic sync_rise;
	assign sclk_rise = sclk_s[1] && !sclk_s[2];
	assign sclk_fall = !sclk_s[1] && sclk_s[2];
	assign cs_fall = !cs_s[1] && cs_s[2];
	assign sel = !cs_s[1];
	assign sync_rise = sync_s[1] && !sync_s[2];

	// ---------------------------------------------------------------
	// SPI frame receive and decode
	// ---------------------------------------------------------------
	logic [15:0] rx_q;
	logic [4:0] rx_cnt_q;
	logic frame_done;
	logic [15:0] cmd;
	logic is_wr;
	logic wr_dc;
	logic wr_ifc;
	assign frame_done = sel && sclk_rise && (rx_cnt_q == aic_pkg::SPI_LAST_BIT);
	assign cmd = {rx_q[14:0], mosi_s[1]};
	assign is_wr = frame_done && !cmd[15];
	assign wr_dc = is_wr && (cmd[14:8] == aic_pkg::REG_DATA_CTRL);
	assign wr_ifc = is_wr && (cmd[14:8] == aic_pkg::REG_IFC_CFG);

	// Bit counter restarts whenever select is released
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !sel) begin
			rx_cnt_q <= 5'h00;
		end else if (sclk_rise) begin
			rx_q <= cmd;
			rx_cnt_q <= rx_cnt_q + 5'h01;
		end
	end

	// ---------------------------------------------------------------
	// Registers and soft reset
	// ---------------------------------------------------------------
	logic soft_rst_q;
	logic rst_all;
	logic armed_q;
	logic post_rst_q;
	logic dc_sync_q;
	logic dc_oneshot_q;
	logic [3:0] ifc_q;
	logic sr_fire;
	logic [7:0] rdata;
	logic [1:0] crc_sel;
	logic [1:0] div_sel;
	assign rst_all = i_sys_rst || soft_rst_q;
	assign crc_sel = ifc_q[aic_pkg::IFC_CRC_LSB +: 2];
	assign div_sel = ifc_q[aic_pkg::IFC_DIV_LSB +: 2];
	// R2: second write only counts straight after the first
	assign sr_fire = wr_dc && armed_q && (cmd[1:0] == aic_pkg::SR_SECOND);
	// R15: undefined bits read as zero
	assign rdata = (cmd[14:8] == aic_pkg::REG_DATA_CTRL) ?
		{dc_sync_q, 2'h0, dc_oneshot_q, 4'h0} :
		(cmd[14:8] == aic_pkg::REG_IFC_CFG) ? {4'h0, ifc_q} : 8'h00;

	// R2: any other write breaks the sequence
	always_ff @(posedge i_mclk) begin
		if (rst_all) begin
			armed_q <= 1'b0;
		end else if (is_wr) begin
			armed_q <= wr_dc && (cmd[1:0] == aic_pkg::SR_FIRST);
		end
	end

	// R3 reset pulse; R4 answer flag armed by it
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			soft_rst_q <= 1'b0;
			post_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= sr_fire;
			if (soft_rst_q) begin
				post_rst_q <= 1'b1;
			end else if (frame_done) begin
				post_rst_q <= 1'b0;
			end
		end
	end

	// R13 reset values; R3 soft reset returns them too; R15 drops other bits
	always_ff @(posedge i_mclk) begin
		if (rst_all) begin
			dc_sync_q <= aic_pkg::DATA_CTRL_RST[aic_pkg::DC_SYNC_BIT];
			dc_oneshot_q <= aic_pkg::DATA_CTRL_RST[aic_pkg::DC_ONESHOT_BIT];
			ifc_q <= aic_pkg::IFC_CFG_RST;
		end else begin
			if (wr_dc) begin
				dc_sync_q <= cmd[aic_pkg::DC_SYNC_BIT];
				dc_oneshot_q <= cmd[aic_pkg::DC_ONESHOT_BIT];
			end
			if (wr_ifc) begin
				ifc_q <= cmd[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// SPI answer: shifted out during the following frame
	// ---------------------------------------------------------------
	logic [15:0] tx_word_q;
	logic [15:0] tx_sh_q;

	// R4: fixed word answers the first command after a soft reset
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			tx_word_q <= 16'h0000;
			tx_sh_q <= 16'h0000;
			o_spi_miso <= 1'b0;
		end else begin
			if (frame_done) begin
				tx_word_q <= post_rst_q ? aic_pkg::POST_RST_WORD : {cmd[15:8], rdata};
			end
			if (cs_fall) begin
				tx_sh_q <= tx_word_q;
				o_spi_miso <= tx_word_q[15];
			end else if (sel && sclk_fall) begin
				tx_sh_q <= {tx_sh_q[14:0], 1'b0};
				o_spi_miso <= tx_sh_q[14];
			end
		end
	end

	// ---------------------------------------------------------------
	// Sync, settling and one-shot admission
	// ---------------------------------------------------------------
	logic hold_q;
	logic shot_q;
	logic gate_open;
	logic take;
	logic admit;
	assign gate_open = !hold_q && (!dc_oneshot_q || shot_q);
	// Samples arriving while the gate is shut are consumed and dropped
	assign take = i_sample_valid && o_sample_ready;
	assign admit = take && gate_open;

	// R14: filter reset on every sync rising edge, hold output until settled
	always_ff @(posedge i_mclk) begin
		if (rst_all) begin
			o_filter_reset <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			o_filter_reset <= sync_rise;
			if (sync_rise) begin
				hold_q <= 1'b1;
			end else if (!o_filter_reset && i_filter_settled) begin
				hold_q <= 1'b0;
			end
		end
	end

	// R1: one token per sync rising edge in one-shot mode
	always_ff @(posedge i_mclk) begin
		if (rst_all || !dc_oneshot_q) begin
			shot_q <= 1'b0;
		end else if (sync_rise) begin
			shot_q <= 1'b1;
		end else if (admit) begin
			shot_q <= 1'b0;
		end
	end

	assign o_core_reset = soft_rst_q;

	// ---------------------------------------------------------------
	// Buffer between admission and the serialiser
	// ---------------------------------------------------------------
	logic b_valid;
	logic b_ready;
	logic [BW-1:0] b_data;
	aic_buf2 #(.W(BW)) u_buf (
		.i_mclk(i_mclk),
		.i_rst(rst_all),
		.i_valid(admit),
		.i_data({i_sample_chan, i_sample_status, i_sample_data}),
		.o_ready(o_sample_ready),
		.o_valid(b_valid),
		.o_data(b_data),
		.i_ready(b_ready)
	);

	// ---------------------------------------------------------------
	// Per-channel CRC and header choice
	// ---------------------------------------------------------------
	// R8: bitwise CRC over 16 data bits, MSB first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [15:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 15; i >= 0; i--) begin
			r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ aic_pkg::CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8

	logic [7:0] crc_q [NCH];
	logic [3:0] cnt_q [NCH];
	logic [CH_W-1:0] p_ch;
	logic [15:0] p_dat;
	logic [7:0] crc_nx;
	logic [3:0] last_n;
	logic crc_slot;
	logic pop;
	logic [7:0] header;
	assign p_ch = b_data[BW-1 -: CH_W];
	assign p_dat = b_data[15:0];
	// R9: CRC per channel over its data only
	assign crc_nx = crc8(crc_q[p_ch], p_dat);
	// R6, R7: slot length follows the select field
	assign last_n = (crc_sel == aic_pkg::CRC_EVERY4) ? aic_pkg::CRC_LAST4 : aic_pkg::CRC_LAST16;
	assign crc_slot = (crc_sel != aic_pkg::CRC_OFF) && (cnt_q[p_ch] == last_n);
	// R5: status header unless this is a CRC slot
	assign header = crc_slot ? crc_nx : b_data[23:16];

	// R9: one accumulator and sample count per channel
	genvar g;
	for (g = 0; g < NCH; g++) begin : g_chan
		always_ff @(posedge i_mclk) begin
			if (rst_all) begin
				crc_q[g] <= aic_pkg::CRC_INIT;
				cnt_q[g] <= 4'h0;
			end else if (pop && (p_ch == CH_W'(g))) begin
				crc_q[g] <= crc_slot ? aic_pkg::CRC_INIT : crc_nx;
				cnt_q[g] <= crc_slot ? 4'h0 : (cnt_q[g] + 4'h1);
			end
		end
	end

	// ---------------------------------------------------------------
	// Data clock divider and serialiser
	// ---------------------------------------------------------------
	logic [3:0] div_n;
	logic [3:0] div_cnt_q;
	logic [3:0] div_cnt_d;
	logic data_output_clock_d;
	logic bit_en;
	logic [23:0] sh_q;
	logic [4:0] left_q;
	// R10: 8 >> field gives 8, 4, 2, 1
	assign div_n = aic_pkg::DIV_MAX >> div_sel;
	assign bit_en = (div_cnt_q == 4'h0);
	assign div_cnt_d = (div_cnt_q + 4'h1 >= div_n) ? 4'h0 : (div_cnt_q + 4'h1);
	// Low in the first half after a bit change, high in the second; divide 1 stays high
	assign data_output_clock_d = (div_cnt_d == 4'h0) || (div_cnt_d > (div_n >> 1));
	assign b_ready = (left_q == 5'h00) && bit_en;
	assign pop = b_valid && b_ready;

	// R11: one data bit per divided period; clock high in second half
	always_ff @(posedge i_mclk) begin
		if (rst_all) begin
			div_cnt_q <= 4'h0;
			o_data_output_clock <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_d;
			o_data_output_clock <= data_output_clock_d;
		end
	end

	// R11: word is header then 16 data bits, MSB first
	always_ff @(posedge i_mclk) begin
		if (rst_all) begin
			sh_q <= 24'h000000;
			left_q <= 5'h00;
			o_data_output_lanes <= 1'b0;
			o_data_frame <= 1'b0;
		end else if (pop) begin
			// Header MSB leaves now, so the shifter starts at header bit 6
			sh_q <= {header[6:0], p_dat, 1'b0};
			left_q <= aic_pkg::FRAME_BITS - 5'h01;
			o_data_output_lanes <= header[7];
			o_data_frame <= 1'b1;
		end else if (bit_en) begin
			o_data_frame <= 1'b0;
			if (left_q != 5'h00) begin
				o_data_output_lanes <= sh_q[23];
				sh_q <= {sh_q[22:0], 1'b0};
				left_q <= left_q - 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_sr_fired;
		sr_fire ##1 soft_rst_q;
	endsequence
	property p_soft_reset;
		@(posedge i_mclk) disable iff (i_sys_rst)
		s_sr_fired |=> (ifc_q == aic_pkg::IFC_CFG_RST) && !dc_oneshot_q && post_rst_q;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state"); // R3
	property p_no_effect;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wr_dc && !cmd[1]) |=> !soft_rst_q;
	endproperty
	a_no_effect: assert property (p_no_effect) else $error("reset field 0/1 acted"); // R2
	property p_post_word;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(frame_done && post_rst_q) |=> (tx_word_q == aic_pkg::POST_RST_WORD) && !post_rst_q;
	endproperty
	a_post_word: assert property (p_post_word) else $error("missing post reset word"); // R4
	property p_oneshot;
		@(posedge i_mclk) disable iff (rst_all)
		(dc_oneshot_q && admit && !sync_rise) |=> !shot_q;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("second sample in one-shot"); // R1
	property p_no_crc;
		@(posedge i_mclk) disable iff (rst_all)
		(pop && crc_sel == aic_pkg::CRC_OFF) |=>
		(sh_q[23:17] == $past(b_data[22:16])) && (o_data_output_lanes == $past(b_data[23]));
	endproperty
	a_no_crc: assert property (p_no_crc) else $error("header not status"); // R5
	property p_crc4;
		@(posedge i_mclk) disable iff (rst_all)
		(pop && crc_sel == aic_pkg::CRC_EVERY4 && cnt_q[p_ch] == 4'h3) |-> header == crc_nx;
	endproperty
	a_crc4: assert property (p_crc4) else $error("no CRC on fourth sample"); // R6
	property p_crc16;
		@(posedge i_mclk) disable iff (rst_all)
		(pop && crc_sel[1] && cnt_q[p_ch] != 4'hf) |-> header == b_data[23:16];
	endproperty
	a_crc16: assert property (p_crc16) else $error("CRC before sixteenth sample"); // R7
	property p_div8;
		@(posedge i_mclk) disable iff (rst_all)
		(div_sel == 2'h0 && bit_en && $stable(div_sel)) |=> (!bit_en || (div_sel != 2'h0)) [*7];
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong"); // R10
	property p_rst_cfg;
		@(posedge i_mclk) $past(i_sys_rst) |-> (ifc_q == 4'h0);
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("config not cleared"); // R13
	property p_settle;
		@(posedge i_mclk) disable iff (rst_all)
		sync_rise |=> o_filter_reset ##1 (hold_q && !admit);
	endproperty
	a_settle: assert property (p_settle) else $error("output during settling"); // R14
endmodule : aic_top
